//--- src/buck_guard_pkg.sv
package buck_guard_pkg;

    // ------------------------------------------------------------
    // register offsets and fields
    // ------------------------------------------------------------
    localparam logic [7:0] OC_LIMIT_ADDR  = 8'h15;
    localparam logic [7:0] OV_LEVEL_ADDR  = 8'h17;
    localparam logic [7:0] OT_LEVEL_ADDR  = 8'h19;
    localparam logic [7:0] STATUS_ADDR    = 8'h1a;
    localparam int         OC_FIELD_W     = 3;
    localparam int         OV_FIELD_W     = 2;
    localparam int         OT_FIELD_W     = 2;
    localparam logic [2:0] OC_LIMIT_RESET = 3'h2;
    localparam logic [1:0] OV_LEVEL_RESET = 2'h3;
    localparam logic [1:0] OT_LEVEL_RESET = 2'h3;
    localparam int         STAT_RUN_BIT   = 0;
    localparam int         STAT_HICC_BIT  = 1;
    localparam int         STAT_OV_BIT    = 2;
    localparam int         STAT_OT_BIT    = 3;
    localparam int         STAT_PG_BIT    = 4;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int OV_DELAY_NS     = 5000;
    localparam int MIN_ON_NS       = 40;
    localparam int MIN_OFF_NS      = 60;
    localparam int HICCUP_BLANK_NS = 20000;
    localparam int OV_DELAY_CYCLES =
        (OV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_ON_CYCLES =
        (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_OFF_CYCLES =
        (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HICCUP_CYCLES =
        (HICCUP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 12;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic enable_above;
        logic bias_above;
        logic oc_over_limit;
        logic current_zero;
        logic ov_above;
        logic ov_below_hyst;
        logic ot_above;
        logic ot_below_hyst;
        logic output_near_zero;
    } sense_flags_t;

    typedef struct packed {
        logic high_side;
        logic low_side;
    } gate_drive_t;

    typedef struct packed {
        logic [2:0] overcurrent_limit_code;
        logic [1:0] overvoltage_level_code;
        logic [1:0] overtemp_level_code;
    } level_codes_t;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_RUN,
        ST_OC_DRAIN,
        ST_HICCUP,
        ST_OV_DISCHARGE,
        ST_OV_HOLD,
        ST_OT_SHUT
    } guard_state_t;

endpackage

//--- src/hold_timer.sv
`timescale 1ns/10ps
module hold_timer #(
    parameter int LIMIT = 16
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic count_en,
    output logic      done
);

    logic [buck_guard_pkg::TIMER_W-1:0] count_reg;
    localparam logic [buck_guard_pkg::TIMER_W-1:0] LIMIT_W =
        buck_guard_pkg::TIMER_W'(LIMIT);

    // ------------------------------------------------------------
    // counts while enabled, saturates at the limit, clears when idle
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst || !count_en) begin
            count_reg <= '0;
        end else if (count_reg != LIMIT_W) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    assign done = count_en && (count_reg == LIMIT_W);

endmodule // hold_timer

//--- src/pulse_sequencer.sv
`timescale 1ns/10ps
module pulse_sequencer (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        run,
    input  wire logic                        cycle_start,
    input  wire logic                        startup,
    input  wire logic [7:0]                  on_cycles,
    output buck_guard_pkg::gate_drive_t      drive,
    output logic                             sample_window
);

    typedef enum logic [1:0] {PH_LOW, PH_HIGH, PH_MIN_OFF} phase_t;

    localparam logic [7:0] MIN_ON_W  = 8'(buck_guard_pkg::MIN_ON_CYCLES);
    localparam logic [7:0] MIN_OFF_W = 8'(buck_guard_pkg::MIN_OFF_CYCLES);

    phase_t     phase_reg;
    logic [7:0] count_reg;
    logic [7:0] on_load;

    // near zero output forces the shortest on pulse
    assign on_load = (startup || on_cycles < MIN_ON_W) ? MIN_ON_W
                                                       : on_cycles;

    // ------------------------------------------------------------
    // on pulse, then minimum off, then low side until next cycle
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst || !run) begin
            phase_reg <= PH_LOW;
            count_reg <= '0;
        end else begin
            unique case (phase_reg)
                PH_LOW: begin
                    if (cycle_start) begin
                        phase_reg <= PH_HIGH;
                        count_reg <= on_load;
                    end
                end
                PH_HIGH: begin
                    if (count_reg <= 8'h01) begin
                        phase_reg <= PH_MIN_OFF;
                        count_reg <= MIN_OFF_W;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
                PH_MIN_OFF: begin
                    if (count_reg <= 8'h01) begin
                        phase_reg <= PH_LOW;
                        count_reg <= '0;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
            endcase
        end
    end

    assign drive.high_side = run && (phase_reg == PH_HIGH);
    assign drive.low_side  = run && (phase_reg != PH_HIGH);
    assign sample_window   = run && (phase_reg == PH_MIN_OFF);

endmodule // pulse_sequencer

//--- src/buck_fault_protection.sv
`timescale 1ns/10ps
module buck_fault_protection (
    input  wire logic                         core_clk,
    input  wire logic                         rst,
    input  wire logic [7:0]                   reg_addr,
    input  wire logic                         reg_write,
    input  wire logic [7:0]                   reg_wdata,
    input  wire logic                         reg_read,
    output logic [7:0]                        reg_rdata,
    input  wire buck_guard_pkg::sense_flags_t sense_in,
    input  wire logic                         pg_in_range,
    input  wire logic                         cycle_start,
    input  wire logic [7:0]                   on_cycles,
    output buck_guard_pkg::gate_drive_t       gate,
    output buck_guard_pkg::level_codes_t      level_codes,
    output logic                              output_good_flag,
    output logic                              soft_start_run,
    output logic                              bias_regulator_on
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    buck_guard_pkg::sense_flags_t sense_meta_reg;
    buck_guard_pkg::sense_flags_t sense_reg;
    buck_guard_pkg::guard_state_t state_reg;
    buck_guard_pkg::guard_state_t state_next;
    buck_guard_pkg::gate_drive_t  seq_drive;
    buck_guard_pkg::gate_drive_t  gate_reg;
    buck_guard_pkg::gate_drive_t  gate_next;

    logic [2:0] oc_code_reg;
    logic [1:0] ov_code_reg;
    logic [1:0] ot_code_reg;
    logic [7:0] rdata_reg;
    logic       output_good_reg;
    logic       soft_start_reg;
    logic       bias_on_reg;
    logic       sample_window;
    logic       seq_run;
    logic       powered;
    logic       oc_fault;
    logic       ov_qualify_en;
    logic       ov_fault;
    logic       hiccup_done;
    logic       ov_active;
    logic       ot_active;

    function automatic logic is_run(input buck_guard_pkg::guard_state_t s);
        return s == buck_guard_pkg::ST_RUN;
    endfunction

    // oc drain and hiccup form the retry loop
    function automatic logic in_retry(input buck_guard_pkg::guard_state_t s);
        return (s == buck_guard_pkg::ST_OC_DRAIN) ||
               (s == buck_guard_pkg::ST_HICCUP);
    endfunction

    // discharge and hold form the over-voltage latch
    function automatic logic in_latch(input buck_guard_pkg::guard_state_t s);
        return (s == buck_guard_pkg::ST_OV_DISCHARGE) ||
               (s == buck_guard_pkg::ST_OV_HOLD);
    endfunction

    // ------------------------------------------------------------
    // comparator flag synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sense_meta_reg <= '0;
            sense_reg      <= '0;
        end else begin
            sense_meta_reg <= sense_in;
            sense_reg      <= sense_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // threshold select registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            oc_code_reg <= buck_guard_pkg::OC_LIMIT_RESET;
            ov_code_reg <= buck_guard_pkg::OV_LEVEL_RESET;
            ot_code_reg <= buck_guard_pkg::OT_LEVEL_RESET;
        end else if (reg_write) begin
            if (reg_addr == buck_guard_pkg::OC_LIMIT_ADDR) begin
                oc_code_reg <= reg_wdata[buck_guard_pkg::OC_FIELD_W-1:0];
            end
            if (reg_addr == buck_guard_pkg::OV_LEVEL_ADDR) begin
                ov_code_reg <= reg_wdata[buck_guard_pkg::OV_FIELD_W-1:0];
            end
            if (reg_addr == buck_guard_pkg::OT_LEVEL_ADDR) begin
                ot_code_reg <= reg_wdata[buck_guard_pkg::OT_FIELD_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_reg <= '0;
        end else if (reg_read) begin
            unique case (reg_addr)
                buck_guard_pkg::OC_LIMIT_ADDR: begin
                    rdata_reg <= {5'h00, oc_code_reg};
                end
                buck_guard_pkg::OV_LEVEL_ADDR: begin
                    rdata_reg <= {6'h00, ov_code_reg};
                end
                buck_guard_pkg::OT_LEVEL_ADDR: begin
                    rdata_reg <= {6'h00, ot_code_reg};
                end
                buck_guard_pkg::STATUS_ADDR: begin
                    rdata_reg <= '0;
                    rdata_reg[buck_guard_pkg::STAT_RUN_BIT] <=
                        is_run(state_reg);
                    rdata_reg[buck_guard_pkg::STAT_HICC_BIT] <=
                        in_retry(state_reg);
                    rdata_reg[buck_guard_pkg::STAT_OV_BIT] <=
                        in_latch(state_reg);
                    rdata_reg[buck_guard_pkg::STAT_OT_BIT] <=
                        (state_reg == buck_guard_pkg::ST_OT_SHUT);
                    rdata_reg[buck_guard_pkg::STAT_PG_BIT] <= output_good_reg;
                end
                default: begin
                    rdata_reg <= '0;
                end
            endcase
        end
    end

    assign reg_rdata = rdata_reg;

    // codes go straight out to the analog comparators
    assign level_codes.overcurrent_limit_code = oc_code_reg;
    assign level_codes.overvoltage_level_code = ov_code_reg;
    assign level_codes.overtemp_level_code    = ot_code_reg;

    // ------------------------------------------------------------
    // switching sequencer
    // ------------------------------------------------------------
    assign seq_run = is_run(state_reg);

    pulse_sequencer u_sequencer (
        .core_clk      (core_clk),
        .rst           (rst),
        .run           (seq_run),
        .cycle_start   (cycle_start),
        .startup       (sense_reg.output_near_zero),
        .on_cycles     (on_cycles),
        .drive         (seq_drive),
        .sample_window (sample_window)
    );

    // ------------------------------------------------------------
    // fault detection and timers
    // ------------------------------------------------------------
    assign powered  = sense_reg.enable_above && sense_reg.bias_above;
    // trip judged only in the minimum-off window,
    // while the low side conducts
    assign oc_fault = sample_window && sense_reg.oc_over_limit;

    assign ov_active = (state_reg == buck_guard_pkg::ST_RUN) ||
                       (state_reg == buck_guard_pkg::ST_OC_DRAIN) ||
                       (state_reg == buck_guard_pkg::ST_HICCUP);
    assign ot_active = ov_active;

    assign ov_qualify_en = ov_active && sense_reg.ov_above;

    hold_timer #(
        .LIMIT (buck_guard_pkg::OV_DELAY_CYCLES)
    ) u_ov_qualify (
        .core_clk (core_clk),
        .rst      (rst),
        .count_en (ov_qualify_en),
        .done     (ov_fault)
    );

    hold_timer #(
        .LIMIT (buck_guard_pkg::HICCUP_CYCLES)
    ) u_hiccup_blank (
        .core_clk (core_clk),
        .rst      (rst),
        .count_en (state_reg == buck_guard_pkg::ST_HICCUP),
        .done     (hiccup_done)
    );

    // ------------------------------------------------------------
    // protection state machine
    // ------------------------------------------------------------
    // supply loss outranks every fault, so the latch clears only via off;
    // over-voltage outranks temperature, temperature the current trip
    always_comb begin
        state_next = state_reg;
        if (!powered) begin
            state_next = buck_guard_pkg::ST_OFF;
        end else if (ov_fault) begin
            state_next = buck_guard_pkg::ST_OV_DISCHARGE;
        end else if (ot_active && sense_reg.ot_above) begin
            state_next = buck_guard_pkg::ST_OT_SHUT;
        end else begin
            unique case (state_reg)
                buck_guard_pkg::ST_OFF: begin
                    state_next = buck_guard_pkg::ST_RUN;
                end
                buck_guard_pkg::ST_RUN: begin
                    if (oc_fault) begin
                        state_next = buck_guard_pkg::ST_OC_DRAIN;
                    end
                end
                buck_guard_pkg::ST_OC_DRAIN: begin
                    if (sense_reg.current_zero) begin
                        state_next = buck_guard_pkg::ST_HICCUP;
                    end
                end
                buck_guard_pkg::ST_HICCUP: begin
                    if (hiccup_done) begin
                        state_next = buck_guard_pkg::ST_RUN;
                    end
                end
                buck_guard_pkg::ST_OV_DISCHARGE: begin
                    if (sense_reg.ov_below_hyst) begin
                        state_next = buck_guard_pkg::ST_OV_HOLD;
                    end
                end
                buck_guard_pkg::ST_OV_HOLD: begin
                    state_next = buck_guard_pkg::ST_OV_HOLD;
                end
                buck_guard_pkg::ST_OT_SHUT: begin
                    if (sense_reg.ot_below_hyst) begin
                        state_next = buck_guard_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_next = buck_guard_pkg::ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= buck_guard_pkg::ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // gate drive
    // ------------------------------------------------------------
    // gates follow the next state, so a fault opens the high side
    // on the same edge that the state changes
    always_comb begin
        gate_next = '0;
        unique case (state_next)
            buck_guard_pkg::ST_RUN: begin
                if (is_run(state_reg)) begin
                    gate_next = seq_drive;
                end
            end
            buck_guard_pkg::ST_OC_DRAIN: begin
                gate_next.low_side = 1'b1;
            end
            buck_guard_pkg::ST_OV_DISCHARGE: begin
                gate_next.low_side = 1'b1;
            end
            default: begin
                gate_next = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            gate_reg <= '0;
        end else begin
            gate_reg <= gate_next;
        end
    end

    assign gate = gate_reg;

    // ------------------------------------------------------------
    // output good, soft-start reference and bias regulator
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            output_good_reg <= 1'b0;
        end else begin
            // any fault state drops output good on the same edge
            output_good_reg <= is_run(state_next) &&
                               is_run(state_reg) &&
                               pg_in_range;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            soft_start_reg <= 1'b0;
        end else begin
            soft_start_reg <= is_run(state_next);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bias_on_reg <= 1'b1;
        end else begin
            bias_on_reg <= 1'b1;
        end
    end

    assign output_good_flag  = output_good_reg;
    assign soft_start_run    = soft_start_reg;
    assign bias_regulator_on = bias_on_reg;

endmodule // buck_fault_protection

//--- verification/buck_fault_protection_props.sv
`timescale 1ns/10ps
module buck_fault_protection_props (
    input wire logic                         core_clk,
    input wire logic                         rst,
    input wire logic [7:0]                   reg_addr,
    input wire logic                         reg_write,
    input wire logic [7:0]                   reg_wdata,
    input wire logic                         reg_read,
    input wire logic [7:0]                   reg_rdata,
    input wire buck_guard_pkg::sense_flags_t sense_in,
    input wire buck_guard_pkg::gate_drive_t  gate,
    input wire buck_guard_pkg::level_codes_t level_codes,
    input wire logic                         output_good_flag,
    input wire logic                         soft_start_run,
    input wire logic                         bias_regulator_on
);
    // ----
    // checks
    // ----
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_BIAS_ON: assert property (bias_regulator_on)
        else $error("bias regulator off");
    AST_GATE_EXCL: assert property (!(gate.high_side && gate.low_side))
        else $error("both switches on");
    AST_EN_OFF: assert property (!sense_in.enable_above [*5]
        |-> gate == '0 && !soft_start_run)
        else $error("enable low but still driving");
    AST_OC_WRITE: assert property (reg_write && reg_addr == 8'h15
        |=> level_codes.overcurrent_limit_code == $past(reg_wdata[2:0]))
        else $error("current limit code not taken");
    AST_OV_WRITE: assert property (reg_write && reg_addr == 8'h17
        |=> level_codes.overvoltage_level_code == $past(reg_wdata[1:0]))
        else $error("voltage level code not taken");
    AST_OT_WRITE: assert property (reg_write && reg_addr == 8'h19
        |=> level_codes.overtemp_level_code == $past(reg_wdata[1:0]))
        else $error("temperature level code not taken");
    AST_OC_READ: assert property (reg_read && reg_addr == 8'h15
        |=> reg_rdata == {5'h00, $past(level_codes.overcurrent_limit_code)})
        else $error("current limit read wrong");
    AST_HIGH_IN_RUN: assert property (gate.high_side |-> soft_start_run)
        else $error("high side on outside regulation");
endmodule // buck_fault_protection_props

bind buck_fault_protection buck_fault_protection_props u_props (
    .core_clk, .rst, .reg_addr, .reg_write, .reg_wdata, .reg_read,
    .reg_rdata, .sense_in, .gate, .level_codes, .output_good_flag,
    .soft_start_run, .bias_regulator_on
);

//--- verification/power_stage_model.sv
`timescale 1ns/10ps
module power_stage_model (
    input  wire logic                         core_clk,
    input  wire buck_guard_pkg::gate_drive_t  gate,
    input  wire buck_guard_pkg::sense_flags_t cmd,
    output buck_guard_pkg::sense_flags_t      sense_in
);
    // ----
    // switch current and comparators
    // ----
    logic [5:0] low_on_reg;
    logic       at_zero;
    always_ff @(posedge core_clk) begin
        if (!gate.low_side) begin
            low_on_reg <= 6'h00;
        end else if (low_on_reg != 6'h3f) begin
            low_on_reg <= low_on_reg + 6'h01;
        end
    end
    // current reads zero with both switches off, or after 30 cycles of low side conduction
    assign at_zero = (gate == '0) || (low_on_reg >= 6'h1e);
    always_comb begin
        sense_in = cmd;
        sense_in.current_zero = at_zero;
        // current is seen only through the conducting low side
        sense_in.oc_over_limit = cmd.oc_over_limit & gate.low_side & !at_zero;
    end
endmodule // power_stage_model

//--- verification/buck_fault_protection_bench.sv
`timescale 1ns/10ps
module buck_fault_protection_bench;
    // ----
    // signals
    // ----
    logic                         core_clk = 1'b0;
    logic                         rst = 1'b1;
    logic [7:0]                   reg_addr = 8'h00;
    logic                         reg_write = 1'b0;
    logic [7:0]                   reg_wdata = 8'h00;
    logic                         reg_read = 1'b0;
    logic [7:0]                   reg_rdata;
    buck_guard_pkg::sense_flags_t cmd = '0;
    buck_guard_pkg::sense_flags_t sense_in;
    logic                         pg_in_range = 1'b0;
    logic                         cycle_start = 1'b0;
    logic [7:0]                   on_cycles = 8'h00;
    buck_guard_pkg::gate_drive_t  gate;
    buck_guard_pkg::level_codes_t level_codes;
    logic                         output_good_flag;
    logic                         soft_start_run;
    logic                         bias_regulator_on;
    logic [7:0]                   d;
    int                           hi;
    int                           lo;
    int                           failures = 0;
    int                           compares = 0;
    buck_fault_protection dut (.core_clk, .rst, .reg_addr, .reg_write,
        .reg_wdata, .reg_read, .reg_rdata, .sense_in, .pg_in_range,
        .cycle_start, .on_cycles, .gate, .level_codes, .output_good_flag,
        .soft_start_run, .bias_regulator_on);
    power_stage_model far (.core_clk, .gate, .cmd, .sense_in);
    // ----
    // tasks
    // ----
    task automatic give_verdict();
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [7:0] s, e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = v;
        reg_write = 1'b1;
        @(negedge core_clk);
        reg_write = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge core_clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge core_clk);
        reg_read = 1'b0;
        v = reg_rdata;
    endtask
    task automatic wait_ss(input int max);
        int n;
        n = 0;
        while (soft_start_run !== 1'b1 && n < max) begin
            @(negedge core_clk);
            n++;
        end
        if (soft_start_run !== 1'b1) begin
            failures++;
            $display("Error soft_start_run expected 1 seen %b", soft_start_run);
            give_verdict();
        end
    endtask
    task automatic pulse(input logic [7:0] on);
        @(negedge core_clk);
        cycle_start = 1'b1;
        on_cycles = on;
        @(negedge core_clk);
        cycle_start = 1'b0;
        hi = 0;
        lo = 0;
        repeat (20) begin
            @(negedge core_clk);
            if (gate.high_side === 1'b1) hi++;
            if (gate.low_side === 1'b1) lo++;
        end
    endtask
    // ----
    // sequence
    // ----
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        cmd.ov_below_hyst = 1'b1;
        cmd.ot_below_hyst = 1'b1;
        step(8);
        rst = 1'b0;
        check("oc code", {5'h00, level_codes.overcurrent_limit_code}, 8'h02);
        check("ov code", {6'h00, level_codes.overvoltage_level_code}, 8'h03);
        check("ot code", {6'h00, level_codes.overtemp_level_code}, 8'h03);
        rd(8'h20, d);
        check("unmapped", d, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(buck_guard_pkg::OC_LIMIT_ADDR, 8'hf8 | 8'(i));
            wr(buck_guard_pkg::OV_LEVEL_ADDR, 8'hfc | 8'(i));
            wr(buck_guard_pkg::OT_LEVEL_ADDR, 8'hfc | 8'(i));
            check("oc code", {5'h00, level_codes.overcurrent_limit_code}, 8'(i));
            rd(buck_guard_pkg::OC_LIMIT_ADDR, d);
            check("oc read", d, 8'(i));
            rd(buck_guard_pkg::OV_LEVEL_ADDR, d);
            check("ov read", d, 8'(i));
            rd(buck_guard_pkg::OT_LEVEL_ADDR, d);
            check("ot read", d, 8'(i));
        end
        pg_in_range = 1'b1;
        cmd.enable_above = 1'b1;
        cmd.bias_above = 1'b1;
        cmd.output_near_zero = 1'b1;
        wait_ss(20);
        pulse(8'h14);
        check("startup on", 8'(hi), 8'(buck_guard_pkg::MIN_ON_CYCLES));
        check("min off", 8'(lo), 8'(20 - buck_guard_pkg::MIN_ON_CYCLES));
        cmd.output_near_zero = 1'b0;
        step(4);
        pulse(8'h0a);
        check("on time", 8'(hi), 8'h0a);
        check("good", {7'h00, output_good_flag}, 8'h01);
        cmd.oc_over_limit = 1'b1;
        pulse(8'h05);
        check("trip good", {7'h00, output_good_flag}, 8'h00);
        check("trip ss", {7'h00, soft_start_run}, 8'h00);
        check("drain", {6'h00, gate}, 8'h01);
        cmd.oc_over_limit = 1'b0;
        step(30);
        check("hiccup", {6'h00, gate}, 8'h00);
        rd(buck_guard_pkg::STATUS_ADDR, d);
        check("hiccup st", {7'h00, d[buck_guard_pkg::STAT_HICC_BIT]}, 8'h01);
        step(1900);
        check("blank", {7'h00, soft_start_run}, 8'h00);
        wait_ss(150);
        cmd.ot_above = 1'b1;
        cmd.ot_below_hyst = 1'b0;
        step(6);
        check("ot gate", {6'h00, gate}, 8'h00);
        check("ot ss", {7'h00, soft_start_run}, 8'h00);
        check("ot bias", {7'h00, bias_regulator_on}, 8'h01);
        cmd.ot_above = 1'b0;
        step(6);
        check("ot hyst", {7'h00, soft_start_run}, 8'h00);
        cmd.ot_below_hyst = 1'b1;
        wait_ss(20);
        for (int k = 0; k < 2; k++) begin
            cmd.ov_above = 1'b1;
            cmd.ov_below_hyst = 1'b0;
            step(450);
            rd(buck_guard_pkg::STATUS_ADDR, d);
            check("ov early", {7'h00, d[buck_guard_pkg::STAT_OV_BIT]}, 8'h00);
            step(80);
            check("ov gate", {6'h00, gate}, 8'h01);
            check("ov good", {7'h00, output_good_flag}, 8'h00);
            cmd.ov_above = 1'b0;
            cmd.ov_below_hyst = 1'b1;
            step(6);
            check("ov hold", {6'h00, gate}, 8'h00);
            pulse(8'h05);
            check("ov latch", 8'(hi), 8'h00);
            // first pass cycles enable, second the bias supply
            if (k == 0) cmd.enable_above = 1'b0;
            else cmd.bias_above = 1'b0;
            step(6);
            cmd.enable_above = 1'b1;
            cmd.bias_above = 1'b1;
            wait_ss(20);
            pulse(8'h05);
            check("unlatched", 8'(hi), 8'h05);
        end
        cmd.enable_above = 1'b0;
        step(6);
        check("en gate", {6'h00, gate}, 8'h00);
        check("en ss", {7'h00, soft_start_run}, 8'h00);
        give_verdict();
    end
endmodule // buck_fault_protection_bench
